// >>> wdtc_top.sv
// wdtc_top.sv - watchdog timer control with wishbone registers
// assumes a single 10 MHz clock; oscillator, fuse and monitor arrive async
`timescale 1ns/100ps
module wdtc_top (
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   // wishbone slave
   input  wire wdtc_pkg::wdtc_wb_req_t wb_req_i,
   output      wdtc_pkg::wdtc_wb_rsp_t wb_rsp_o,
   // asynchronous pins
   input  wire logic                  osc_i,
   input  wire logic                  always_on_fuse_i,
   input  wire logic                  clk_monitor_i,
   // processor core
   input  wire logic                  global_irq_enable_i,
   input  wire logic                  vector_taken_i,
   input  wire logic                  restart_i,
   output      logic                  timeout_irq_o,
   // system side
   output      logic                  sys_reset_o,
   output      logic                  irq_o
);
   import wdtc_pkg::*;

   wdtc_state_t s;
   wdtc_state_t next_s;
   wdtc_mode_t  mode;
   wdtc_mode_t  next_mode;
   logic        tick;
   logic        tmo;
   logic        acc;
   logic        wr;
   logic        ctl_wr;
   logic        vec;
   logic        restart;
   logic [31:0] wd;

   ////////////////////////////////////////////////////////////////////////
   // functions

   // effective mode from stored enables, fuse, monitor and cause flag
   function automatic wdtc_mode_t mode_of(input logic ie, input logic re,
                                          input logic fuse, input logic mon,
                                          input logic rcf);
      logic re_eff;
      logic ie_eff;
      re_eff = re | rcf | fuse | (mon & ie);
      ie_eff = ie & ~fuse & ~mon;
      if (re_eff && ie_eff) begin
         return WDTC_BOTH;
      end else if (re_eff) begin
         return WDTC_RST;
      end else if (ie_eff) begin
         return WDTC_INT;
      end else begin
         return WDTC_STOPPED;
      end
   endfunction

   // last count before timeout; reserved codes act as the longest period
   function automatic logic [WDTC_CNT_W-1:0] last_count(input logic [3:0] sel);
      logic [3:0]  k;
      logic [20:0] p;
      k = (sel > WDTC_SEL_MAX) ? WDTC_SEL_MAX : sel;
      p = WDTC_BASE_CYCLES << k;
      return WDTC_CNT_W'(p - 21'h000001);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // decode of the present cycle

   // oscillator edge seen only after the second sync stage
   assign tick    = s.osc[1] & ~s.osc[2];
   assign mode    = mode_of(s.timeout_irq_enable, s.wde, s.fuse_sy[1], s.mon_sy[1], s.rcf);
   assign tmo     = tick && (mode != WDTC_STOPPED) && (s.count == last_count(s.sel));
   // writes land on the edge where the master sees ack
   assign acc     = wb_req_i.cyc & wb_req_i.stb;
   assign wr      = acc & wb_req_i.we & s.rsp.ack;
   assign wd      = wb_req_i.dat;
   assign ctl_wr  = wr & wb_req_i.sel[0] & (wb_req_i.adr == WDTC_CTRL_OFS);
   assign vec     = vector_taken_i & s.wdt_irq;
   assign restart = restart_i | (wr & (wb_req_i.adr == WDTC_RESTART_OFS));

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      logic [3:0]          sel_new;
      logic [WDTC_EV_W-1:0] ev;
      logic [WDTC_EV_W-1:0] clr;
      next_s  = s;
      sel_new = {wd[WDTC_SEL3_BIT], wd[2:0]};
      ev      = '0;
      clr     = '0;
      // two-stage synchronisers, first stage feeds only the second
      next_s.osc     = {s.osc[1:0], osc_i};
      next_s.fuse_sy = {s.fuse_sy[0], always_on_fuse_i};
      next_s.mon_sy  = {s.mon_sy[0], clk_monitor_i};
      next_s.sys_rst = 1'b0;

      // unlock window counts system clocks, not oscillator ticks
      if (s.ucnt != 3'h0) begin
         next_s.ucnt = s.ucnt - 3'h1;
      end

      // control register write
      // locked fields are judged one by one, the rest of the write still lands
      if (ctl_wr) begin
         next_s.timeout_irq_enable = wd[WDTC_IE_BIT];
         if (wd[WDTC_RE_BIT]) begin
            next_s.wde = 1'b1;
         end else if (s.unlock && !s.rcf) begin
            next_s.wde = 1'b0;
         end else if (s.wde || s.rcf) begin
            ev[WDTC_EV_REJ] = 1'b1;
         end
         if (sel_new != s.sel) begin
            if (s.unlock) begin
               next_s.sel = sel_new;
            end else begin
               ev[WDTC_EV_REJ] = 1'b1;
            end
         end
         if (wd[WDTC_FLAG_BIT]) begin
            next_s.flag = 1'b0;
         end
         // a fresh unlock judged only later writes, never this one
         if (wd[WDTC_UNLOCK_BIT]) begin
            next_s.ucnt = WDTC_UNLOCK_CYCLES;
         end
      end
      next_s.unlock = (next_s.ucnt != 3'h0);

      // vector taken by the core
      if (vec) begin
         next_s.flag = 1'b0;
         if (mode == WDTC_BOTH) begin
            next_s.timeout_irq_enable = 1'b0;
         end
      end

      // counter
      // stopping also zeroes it, so a later enable starts a full period
      if (mode == WDTC_STOPPED || restart) begin
         next_s.count = '0;
      end else if (tmo) begin
         next_s.count = '0;
      end else if (tick) begin
         next_s.count = s.count + WDTC_CNT_W'(1);
      end

      // action on timeout, set wins over clears above
      if (tmo) begin
         ev[WDTC_EV_TMO] = 1'b1;
         case (mode)
            WDTC_INT: begin
               next_s.flag = 1'b1;
            end
            WDTC_RST: begin
               next_s.sys_rst = 1'b1;
            end
            WDTC_BOTH: begin
               if (s.flag && !vec) begin
                  next_s.sys_rst = 1'b1;
               end else begin
                  next_s.flag = 1'b1;
               end
            end
            default: begin
               next_s.count = '0;
            end
         endcase
      end

      // fuse pins the enables regardless of software
      if (s.fuse_sy[1]) begin
         next_s.wde  = 1'b1;
         next_s.timeout_irq_enable = 1'b0;
      end

      // reset-cause flag, write one clears, own reset sets
      if (wr && wb_req_i.adr == WDTC_RSTAT_OFS && wd[WDTC_RCF_BIT]) begin
         next_s.rcf = 1'b0;
      end
      if (next_s.sys_rst) begin
         next_s.rcf = 1'b1;
         ev[WDTC_EV_RST] = 1'b1;
      end

      // sticky events and mask
      if (wr && wb_req_i.adr == WDTC_ISTAT_OFS) begin
         clr = wd[WDTC_EV_W-1:0];
      end
      if (wr && wb_req_i.adr == WDTC_IMASK_OFS) begin
         next_s.imask = wd[WDTC_EV_W-1:0];
      end
      next_s.ists = (s.ists & ~clr) | ev;
      next_s.irq  = |(next_s.ists & next_s.imask);

      // mode after this edge; pins taken from the settled sync stage only,
      // the first stage may still be metastable
      next_mode = mode_of(next_s.timeout_irq_enable, next_s.wde, s.fuse_sy[1], s.mon_sy[1],
                          next_s.rcf);
      // request to the core only while the core accepts interrupts
      next_s.wdt_irq = next_s.flag & global_irq_enable_i
                       & ((next_mode == WDTC_INT) || (next_mode == WDTC_BOTH));

      // bus answer, one wait state, unmapped reads give zero
      next_s.rsp.ack = acc & ~s.rsp.ack;
      next_s.rsp.dat = '0;
      if (acc && !s.rsp.ack && !wb_req_i.we) begin
         case (wb_req_i.adr)
            WDTC_CTRL_OFS: begin
               next_s.rsp.dat[7:0] = {s.flag, s.timeout_irq_enable, s.sel[3], s.unlock,
                                      s.wde | s.rcf, s.sel[2:0]};
            end
            WDTC_RSTAT_OFS: begin
               next_s.rsp.dat[WDTC_RCF_BIT] = s.rcf;
            end
            WDTC_ISTAT_OFS: begin
               next_s.rsp.dat[WDTC_EV_W-1:0] = s.ists;
            end
            WDTC_IMASK_OFS: begin
               next_s.rsp.dat[WDTC_EV_W-1:0] = s.imask;
            end
            WDTC_COUNT_OFS: begin
               next_s.rsp.dat[WDTC_CNT_W-1:0] = s.count;
            end
            default: begin
               next_s.rsp.dat = '0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register

   // whole block state in one register, synchronous reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= WDTC_STATE_RST;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from flops
   assign wb_rsp_o      = s.rsp;
   assign timeout_irq_o = s.wdt_irq;
   assign sys_reset_o   = s.sys_rst;
   assign irq_o         = s.irq;

   ////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_unlock_expire: assert property (
      ($rose(s.unlock) && !ctl_wr) ##1 (!ctl_wr)[*3] |=> !s.unlock)
      else $error("unlock bit outlived four cycles");

   a_int_only: assert property (
      tmo && mode == WDTC_INT |=> s.flag && !s.sys_rst)
      else $error("interrupt mode timeout did not set flag");

   a_combined_first: assert property (
      tmo && mode == WDTC_BOTH && !s.flag |=> s.flag && !s.sys_rst)
      else $error("first combined timeout misbehaved");

   a_vector_clears: assert property (
      vec && mode == WDTC_BOTH && !tmo && !ctl_wr |=> !s.flag && !s.timeout_irq_enable)
      else $error("vector did not clear enable and flag");

   a_second_reset: assert property (
      tmo && mode == WDTC_BOTH && s.flag && !vec |=> s.sys_rst ##1 !s.sys_rst)
      else $error("unserviced second timeout gave no reset");

   a_monitor_reset: assert property (
      s.mon_sy[1] && tmo |=> s.sys_rst && !s.wdt_irq)
      else $error("clock monitor timeout did not reset");

   a_locked_select: assert property (
      ctl_wr && !s.unlock |=> s.sel == $past(s.sel))
      else $error("select changed while locked");

   a_cause_holds_re: assert property (
      s.rcf && s.wde && !tmo |=> s.wde)
      else $error("reset enable cleared with cause flag set");

   a_fuse_reset: assert property (
      s.fuse_sy[1] && tmo |=> s.sys_rst && s.rcf)
      else $error("fuse mode timeout did not reset");

   a_restart_zero: assert property (
      restart |=> s.count == '0)
      else $error("restart did not zero counter");

   a_stopped_idle: assert property (
      mode == WDTC_STOPPED |=> s.count == '0 && !s.sys_rst)
      else $error("stopped watchdog acted");

   a_bus_ack: assert property (
      acc && !s.rsp.ack |=> s.rsp.ack ##1 !s.rsp.ack)
      else $error("wishbone ack not a single cycle");

   // flag clearing, counter steps, lock events and idle bus data
   a_flag_w1c: assert property (
      ctl_wr && wd[WDTC_FLAG_BIT] && !tmo |=> !s.flag)
      else $error("flag not cleared by a written one");

   a_tick_step: assert property (
      tick && mode != WDTC_STOPPED && !restart && !tmo
      |=> s.count == $past(s.count) + WDTC_CNT_W'(1))
      else $error("counter did not advance on oscillator edge");

   a_count_hold: assert property (
      !tick && !restart && mode != WDTC_STOPPED |=> s.count == $past(s.count))
      else $error("counter moved without oscillator edge");

   a_global_gate: assert property (
      !global_irq_enable_i |=> !s.wdt_irq)
      else $error("interrupt request with global enable off");

   a_reject_event: assert property (
      ctl_wr && !s.unlock && !wd[WDTC_RE_BIT] && s.wde |=> s.ists[WDTC_EV_REJ])
      else $error("locked clear of reset enable not flagged");

   a_unlock_set: assert property (
      ctl_wr && wd[WDTC_UNLOCK_BIT] |=> s.unlock)
      else $error("unlock bit did not set");

   a_read_zero: assert property (
      !s.rsp.ack |-> s.rsp.dat == '0)
      else $error("read data not zero outside ack");

   c_combined_irq: cover property (
      tmo && mode == WDTC_BOTH && !s.flag ##[1:20] vec);
   c_second_reset: cover property (s.sys_rst && $past(mode) == WDTC_BOTH);
   c_unlock_change: cover property (ctl_wr && s.unlock && wd[WDTC_RE_BIT] == 1'b0);
   c_rejected: cover property (s.ists[WDTC_EV_REJ]);
   c_monitor_reset: cover property (s.sys_rst && s.mon_sy[1]);
endmodule

// >>> wdtc_pkg.sv
// wdtc_pkg.sv - constants, carriers and state of the watchdog timer control
// assumes a classic wishbone master on a 10 MHz system clock
// Overview of operation
// - ie=1, re=0, fuse off: interrupt mode, request when global enable set.
// - ie=1, re=1: combined mode; first timeout sets the flag, no reset.
// - combined mode: vector taken clears interrupt enable and flag.
// - combined mode: second timeout with interrupt unserviced resets the system.
// - clock monitor with any enable set forces reset mode, no interrupt.
// - clearing reset enable or changing select needs the unlock bit set.
// - unlock bit clears itself four system clock cycles after being set.
// - reset enable reads one while reset-cause flag set; clear that first.
// - select codes 0..9 give 2048 up to 1048576 oscillator cycles.
// - control bits: select 5 and 2..0, ie 6, unlock 4, re 3.
// - counter advances on cycles of the separate slow oscillator.
// - always-on fuse holds reset enable at one and interrupt enable zero.
// - timeout flag bit 7, cleared by vector taken or writing one.
package wdtc_pkg;
   // register byte offsets
   localparam logic [7:0] WDTC_CTRL_OFS    = 8'h00;
   localparam logic [7:0] WDTC_RSTAT_OFS   = 8'h04;
   localparam logic [7:0] WDTC_ISTAT_OFS   = 8'h08;
   localparam logic [7:0] WDTC_IMASK_OFS   = 8'h0C;
   localparam logic [7:0] WDTC_RESTART_OFS = 8'h10;
   localparam logic [7:0] WDTC_COUNT_OFS   = 8'h14;
   // control field positions
   localparam int WDTC_FLAG_BIT   = 7;
   localparam int WDTC_IE_BIT     = 6;
   localparam int WDTC_SEL3_BIT   = 5;
   localparam int WDTC_UNLOCK_BIT = 4;
   localparam int WDTC_RE_BIT     = 3;
   localparam int WDTC_RCF_BIT    = 0;
   // event bits of status and mask
   localparam int WDTC_EV_TMO = 0;
   localparam int WDTC_EV_RST = 1;
   localparam int WDTC_EV_REJ = 2;
   localparam int WDTC_EV_W   = 3;
   // timing and counter
   localparam logic [2:0]  WDTC_UNLOCK_CYCLES = 3'h4;
   localparam logic [20:0] WDTC_BASE_CYCLES   = 21'h000800;
   localparam logic [3:0]  WDTC_SEL_MAX       = 4'h9;
   localparam int          WDTC_CNT_W         = 20;
   localparam logic [7:0]  WDTC_CTRL_RST      = 8'h00;

   typedef enum logic [3:0] {
      WDTC_STOPPED = 4'b0001,
      WDTC_INT     = 4'b0010,
      WDTC_RST     = 4'b0100,
      WDTC_BOTH    = 4'b1000
   } wdtc_mode_t;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [7:0]  adr;
      logic [31:0] dat;
   } wdtc_wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } wdtc_wb_rsp_t;

   typedef struct packed {
      logic [2:0]            osc;
      logic [1:0]            fuse_sy;
      logic [1:0]            mon_sy;
      logic                  flag;
      logic                  timeout_irq_enable;
      logic                  wde;
      logic                  unlock;
      logic [3:0]            sel;
      logic [2:0]            ucnt;
      logic                  rcf;
      logic [WDTC_CNT_W-1:0] count;
      logic [WDTC_EV_W-1:0]  ists;
      logic [WDTC_EV_W-1:0]  imask;
      logic                  irq;
      logic                  wdt_irq;
      logic                  sys_rst;
      wdtc_wb_rsp_t          rsp;
   } wdtc_state_t;

   localparam wdtc_state_t WDTC_STATE_RST = '0;
endpackage

// >>> wdtc_core_model.sv
// wdtc_core_model.sv - processor core as seen by the watchdog
// assumes the bench system clock; makes the slow clock and vectors
`timescale 1ns/100ps
module wdtc_core_model (
   // clock and control from the bench
   input  wire logic clk_i,
   input  wire logic run_i,
   input  wire logic svc_i,
   // watchdog side
   input  wire logic irq_i,
   output      logic osc_o,
   output      logic vec_o
);
   logic [1:0] div   = 2'h0;
   logic       osc_q = 1'b0;
   logic       vec_q = 1'b0;
   assign osc_o = osc_q;
   assign vec_o = vec_q;
   // slow clock, one period per four system clocks to keep runs short
   always @(posedge clk_i) begin
      div <= div + 2'h1;
      if (run_i && div[0]) begin
         osc_q <= ~osc_q;
      end
   end
   // core vectors at once when servicing is on
   always @(posedge clk_i) begin
      vec_q <= svc_i && irq_i && !vec_q;
   end
endmodule

// >>> test_watchdog_timer_control.sv
// test_watchdog_timer_control.sv - self-checking bench for wdtc_top
// assumes wdtc_pkg and wdtc_core_model are compiled first
`timescale 1ns/100ps
module test_watchdog_timer_control;
   import wdtc_pkg::*;
   logic         clk_i, rst_i, fuse, mon, gie, rstrt, run, svc, osc, vec;
   logic         tirq, srst, irq;
   wdtc_wb_req_t req;
   wdtc_wb_rsp_t rsp;
   logic [31:0]  rd;
   int           n_fail, n_tests, n_rst;

   wdtc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
      .osc_i(osc), .always_on_fuse_i(fuse), .clk_monitor_i(mon),
      .global_irq_enable_i(gie), .vector_taken_i(vec), .restart_i(rstrt),
      .timeout_irq_o(tirq), .sys_reset_o(srst), .irq_o(irq));
   wdtc_core_model core (.clk_i(clk_i), .run_i(run), .svc_i(svc), .irq_i(tirq),
      .osc_o(osc), .vec_o(vec));

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // count reset pulses; the pulse lasts one cycle only
   always @(posedge clk_i)
      if (srst === 1'b1)
         n_rst <= n_rst + 1;

   ////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   // one classic cycle, held until ack, then idle one cycle
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      req <= '{1'b1, 1'b1, we, 4'hF, a, d};
      do begin
         @(posedge clk_i);
      end while (rsp.ack !== 1'b1);
      rd = rsp.dat;
      req <= '0;
      @(posedge clk_i);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
      wb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge clk_i);
   endtask
   // waits for the interrupt or the reset output, bounded
   task automatic wait_hi(input logic on_rst, output int n);
      n = 0;
      while (((on_rst ? srst : tirq) !== 1'b1) && n < 9000) begin
         @(posedge clk_i);
         n++;
      end
      chk("wait bound", 32'h1, 32'(n < 9000));
   endtask

   ////////////////////////////////////////////////////////////
   task automatic t_reset();
      rdc(WDTC_CTRL_OFS, 32'h0, "ctrl reset");
      rdc(8'h40, 32'h0, "unmapped");
      run <= 1'b1;
      tick(200);
      rdc(WDTC_COUNT_OFS, 32'h0, "stopped count");
   endtask
   task automatic t_lock();
      wb(1'b1, WDTC_CTRL_OFS, 32'h0D);
      rdc(WDTC_CTRL_OFS, 32'h08, "locked select");
      wb(1'b0, WDTC_ISTAT_OFS, 32'h0);
      chk("reject event", 32'h4, rd & 32'h4);
      wb(1'b1, WDTC_CTRL_OFS, 32'h18);
      wb(1'b1, WDTC_CTRL_OFS, 32'h21);
      rdc(WDTC_CTRL_OFS, 32'h21, "unlocked change");
      wb(1'b1, WDTC_CTRL_OFS, 32'h39);
      tick(4);
      wb(1'b1, WDTC_CTRL_OFS, 32'h00);
      rdc(WDTC_CTRL_OFS, 32'h29, "unlock expiry");
      wb(1'b1, WDTC_CTRL_OFS, 32'h39);
      wb(1'b1, WDTC_CTRL_OFS, 32'h00);
      wb(1'b1, WDTC_ISTAT_OFS, 32'h4);
      rdc(WDTC_ISTAT_OFS, 32'h0, "status clear");
   endtask
   task automatic t_int();
      int n;
      wb(1'b1, WDTC_IMASK_OFS, 32'h1);
      gie <= 1'b1;
      wb(1'b1, WDTC_CTRL_OFS, 32'h40);
      tick(200);
      wb(1'b0, WDTC_COUNT_OFS, 32'h0);
      chk("count runs", 32'h1, 32'(rd > 32'h10));
      rstrt <= 1'b1;
      tick(1);
      rstrt <= 1'b0;
      wb(1'b0, WDTC_COUNT_OFS, 32'h0);
      chk("restart", 32'h1, 32'(rd < 32'h4));
      wait_hi(1'b0, n);
      chk("period", 32'h1, 32'(n > 8150 && n < 8250));
      tick(2);
      rdc(WDTC_CTRL_OFS, 32'hC0, "flag set");
      chk("no reset", 32'h0, n_rst);
      chk("irq raised", 32'h1, 32'(irq));
      gie <= 1'b0;
      tick(3);
      chk("global off", 32'h0, 32'(tirq));
      wb(1'b1, WDTC_CTRL_OFS, 32'hC0);
      rdc(WDTC_CTRL_OFS, 32'h40, "flag w1c");
      wb(1'b1, WDTC_IMASK_OFS, 32'h0);
      tick(2);
      chk("irq masked", 32'h0, 32'(irq));
      wb(1'b1, WDTC_ISTAT_OFS, 32'h1);
      wb(1'b1, WDTC_IMASK_OFS, 32'h1);
      tick(2);
      chk("irq cleared", 32'h0, 32'(irq));
      wb(1'b1, WDTC_CTRL_OFS, 32'h00);
   endtask
   task automatic t_comb();
      int n;
      gie <= 1'b1;
      svc <= 1'b1;
      wb(1'b1, WDTC_RESTART_OFS, 32'h0);
      wb(1'b1, WDTC_CTRL_OFS, 32'h48);
      wait_hi(1'b0, n);
      tick(4);
      rdc(WDTC_CTRL_OFS, 32'h08, "vector clears");
      chk("first timeout", 32'h0, n_rst);
      svc <= 1'b0;
      wb(1'b1, WDTC_RESTART_OFS, 32'h0);
      wb(1'b1, WDTC_CTRL_OFS, 32'h48);  // re-armed outside the handler
      wait_hi(1'b0, n);
      chk("flag only", 32'h0, n_rst);
      wait_hi(1'b1, n);
      tick(2);
      chk("second timeout", 32'h1, n_rst);
      rdc(WDTC_RSTAT_OFS, 32'h1, "cause flag");
      wb(1'b1, WDTC_CTRL_OFS, 32'h18);
      wb(1'b1, WDTC_CTRL_OFS, 32'h80);
      wb(1'b0, WDTC_CTRL_OFS, 32'h0);
      chk("held enable", 32'h8, rd & 32'h8);
      wb(1'b1, WDTC_RSTAT_OFS, 32'h1);
      wb(1'b1, WDTC_CTRL_OFS, 32'h18);
      wb(1'b1, WDTC_CTRL_OFS, 32'h80);
      rdc(WDTC_CTRL_OFS, 32'h0, "enable cleared");
   endtask
   // monitor alone keeps it stopped; with ie it resets and never interrupts
   task automatic t_mon();
      int n;
      mon <= 1'b1;
      tick(40);
      rdc(WDTC_COUNT_OFS, 32'h0, "monitor idle");
      wb(1'b1, WDTC_CTRL_OFS, 32'h40);
      wb(1'b1, WDTC_RESTART_OFS, 32'h0);
      wait_hi(1'b1, n);
      chk("monitor no irq", 32'h0, 32'(tirq));
      tick(2);
      chk("monitor reset", 32'h2, n_rst);
      wb(1'b1, WDTC_RSTAT_OFS, 32'h1);
      wb(1'b1, WDTC_CTRL_OFS, 32'h00);
      mon <= 1'b0;
   endtask
   task automatic t_fuse();
      int n;
      fuse <= 1'b1;
      tick(4);
      wb(1'b1, WDTC_RESTART_OFS, 32'h0);
      wb(1'b1, WDTC_CTRL_OFS, 32'h40);
      wb(1'b0, WDTC_CTRL_OFS, 32'h0);
      chk("fuse ie", 32'h0, rd & 32'h40);
      wait_hi(1'b1, n);
      chk("fuse no irq", 32'h0, 32'(tirq));
      tick(1);
      chk("fuse reset", 32'h3, n_rst);
      fuse <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // watchdog of the bench itself, about half again the expected run
   initial begin
      #(100 * 75000);
      n_fail++;
      results();
   end
   initial begin
      rst_i = 1'b1;
      req = '0;
      fuse = 1'b0;
      mon = 1'b0;
      gie = 1'b0;
      rstrt = 1'b0;
      run = 1'b0;
      svc = 1'b0;
      n_fail = 0;
      n_tests = 0;
      tick(8);
      rst_i <= 1'b0;
      tick(1);
      t_reset();
      t_lock();
      t_int();
      t_comb();
      t_mon();
      t_fuse();
      results();
   end
endmodule
